// ==== design/cri_pkg.sv ====
// package for the cpu reset and initial-state block
// assumes a 100 MHz clk_sys and an avalon-mm register slave
// Overview of operation
// - reset loads program counter with 8000h
// - reset loads system stack pointer 100h
// - reset sets privilege mode bit
// - reset sets interrupt mask field 111
// - reset clears address range mode bit
// - reset sets register bank pointer 000
// - other cpu registers keep their values
// - peripheral registers return to initial values
// - ports become general purpose inputs
// - watchdog pin low, watchdog enabled after
// - clock output pulled high during reset
// - address latch enable low during reset
// - bus release waits for wait end
package cri_pkg;
    localparam int unsigned RST_MIN_CYC = 10;
    localparam logic [23:0] PC_INIT = 24'h008000;
    localparam logic [31:0] XSP_INIT = 32'h00000100;
    localparam logic PRIV_INIT = 1'h1;
    localparam logic [2:0] IMASK_INIT = 3'h7;
    localparam logic MAX_INIT = 1'h0;
    localparam logic [2:0] RFP_INIT = 3'h0;
    localparam logic [7:0] PDIR_INIT = 8'h00;
    localparam logic [7:0] PFUNC_INIT = 8'h00;
    localparam logic [7:0] POUT_INIT = 8'h00;
    localparam logic [15:0] PERIPH_INIT = 16'h0000;
    localparam logic WDT_EN_INIT = 1'h1;
    localparam logic [1:0] CLKDIV_INIT = 2'h0;
    // byte offsets of the register map
    localparam logic [5:0] OFS_STAT = 6'h00;
    localparam logic [5:0] OFS_PC = 6'h04;
    localparam logic [5:0] OFS_XSP = 6'h08;
    localparam logic [5:0] OFS_PSW = 6'h0c;
    localparam logic [5:0] OFS_GPR = 6'h10;
    localparam logic [5:0] OFS_PDIR = 6'h14;
    localparam logic [5:0] OFS_PFUNC = 6'h18;
    localparam logic [5:0] OFS_POUT = 6'h1c;
    localparam logic [5:0] OFS_PIN = 6'h20;
    localparam logic [5:0] OFS_PERIPH = 6'h24;
    localparam logic [5:0] OFS_WDT = 6'h28;
    localparam logic [5:0] OFS_BUS = 6'h2c;
    // watchdog control bits
    localparam int unsigned WDT_EN_BIT = 0;
    localparam int unsigned WDT_CLR_BIT = 1;

    typedef struct packed {
        logic privilege_mode_bit;
        logic [2:0] interrupt_mask_field;
        logic max_mode;
        logic [2:0] register_bank_pointer;
        logic [7:0] flags;
    } cri_psw_t;

    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } cri_avs_req_t;

    typedef enum logic [4:0] {
        BUS_IDLE = 5'h01,
        BUS_ALE = 5'h02,
        BUS_STROBE = 5'h04,
        BUS_WAIT = 5'h08,
        BUS_REL = 5'h10
    } cri_bus_state_t;
endpackage

// ==== design/cri_low_filter.sv ====
// low-level acceptance filter for the reset pin
// assumes level_n is synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module cri_low_filter #(
    parameter int unsigned COUNT = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic level_n,
    output logic accepted
);
    localparam int unsigned W = $clog2(COUNT + 1);
    localparam logic [W-1:0] CNT_MAX = W'(COUNT);
    localparam logic [W-1:0] CNT_LAST = W'(COUNT - 1);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            accepted <= 1'b0;
        end else if (level_n) begin
            cnt_reg <= '0;
            accepted <= 1'b0;
        end else begin
            if (cnt_reg != CNT_MAX) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            if (cnt_reg >= CNT_LAST) begin
                accepted <= 1'b1;
            end
        end
    end
endmodule // cri_low_filter
`default_nettype wire

// ==== design/cri_reset_core.sv ====
// reset acceptance and initial-state logic with avalon-mm registers
// assumes all inputs synchronous to clk_sys; pins resolved outside
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cri_reset_core #(
    parameter int unsigned RST_CYC = cri_pkg::RST_MIN_CYC,
    parameter int unsigned WDT_CYC = 65536
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic reset_pin_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe_n,
    output logic [7:0] port_func,
    output logic [15:0] periph_ctrl,
    output logic watchdog_output_pin,
    output logic clk_out,
    output logic clk_out_oe_n,
    output logic ale,
    input wire logic wait_n,
    input wire logic bus_release_request_n,
    output logic bus_release_grant_n,
    output logic cpu_run,
    output logic [23:0] fetch_addr
);
    ////////////////////////////////////////////////////////////////
    logic in_reset;
    cri_pkg::cri_avs_req_t req;
    logic ack_reg;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] rdata_next;
    logic [23:0] pc_reg;
    logic [31:0] xsp_reg;
    cri_pkg::cri_psw_t psw_reg;
    cri_pkg::cri_psw_t psw_wr;
    logic [31:0] gpr_reg;
    logic [7:0] pdir_reg;
    logic [7:0] pfunc_reg;
    logic [7:0] pout_reg;
    logic [15:0] periph_reg;
    logic wdt_en_reg;
    logic [31:0] wdt_cnt_reg;
    logic wdt_pin_reg;
    logic wdt_clr;
    logic wdt_fire;
    logic [1:0] div_reg;
    logic clk_out_reg;
    cri_pkg::cri_bus_state_t bus_reg;
    cri_pkg::cri_bus_state_t bus_next;
    logic bus_start;

    // consecutive low samples of the reset pin
    cri_low_filter #(
        .COUNT(RST_CYC)
    ) u_filter (
        .clk(clk_sys),
        .nrst(nrst),
        .level_n(reset_pin_n),
        .accepted(in_reset)
    );

    ////////////////////////////////////////////////////////////////
    // avalon slave: one wait state, answer on the second edge
    assign req = '{avs_address, avs_read, avs_write, avs_writedata,
                   avs_byteenable};
    assign avs_waitrequest = (req.read | req.write) & ~ack_reg;
    assign wr_en = req.write & ack_reg;
    assign wmask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    assign psw_wr = cri_pkg::cri_psw_t'(
        (req.writedata[15:0] & wmask[15:0]) |
        (psw_reg & ~wmask[15:0]));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (req.read | req.write) & ~ack_reg;
        end
    end

    always_comb begin
        rdata_next = 32'h00000000;
        case (req.address)
            cri_pkg::OFS_STAT: rdata_next = {25'h0, bus_reg, cpu_run,
                                             in_reset};
            cri_pkg::OFS_PC: rdata_next = {8'h00, pc_reg};
            cri_pkg::OFS_XSP: rdata_next = xsp_reg;
            cri_pkg::OFS_PSW: rdata_next = {16'h0000, psw_reg};
            cri_pkg::OFS_GPR: rdata_next = gpr_reg;
            cri_pkg::OFS_PDIR: rdata_next = {24'h0, pdir_reg};
            cri_pkg::OFS_PFUNC: rdata_next = {24'h0, pfunc_reg};
            cri_pkg::OFS_POUT: rdata_next = {24'h0, pout_reg};
            cri_pkg::OFS_PIN: rdata_next = {24'h0, port_in};
            cri_pkg::OFS_PERIPH: rdata_next = {16'h0, periph_reg};
            cri_pkg::OFS_WDT: rdata_next = {30'h0, wdt_pin_reg,
                                            wdt_en_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h00000000;
        end else if (req.read && !ack_reg) begin
            avs_readdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // cpu state: writes are locked out while reset is accepted
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pc_reg <= cri_pkg::PC_INIT;
        end else if (in_reset) begin
            pc_reg <= cri_pkg::PC_INIT;
        end else if (wr_en && req.address == cri_pkg::OFS_PC) begin
            pc_reg <= (req.writedata[23:0] & wmask[23:0]) |
                      (pc_reg & ~wmask[23:0]);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            xsp_reg <= cri_pkg::XSP_INIT;
        end else if (in_reset) begin
            xsp_reg <= cri_pkg::XSP_INIT;
        end else if (wr_en && req.address == cri_pkg::OFS_XSP) begin
            xsp_reg <= (req.writedata & wmask) | (xsp_reg & ~wmask);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            psw_reg <= '{cri_pkg::PRIV_INIT, cri_pkg::IMASK_INIT,
                         cri_pkg::MAX_INIT, cri_pkg::RFP_INIT, 8'h00};
        end else if (in_reset) begin
            psw_reg.privilege_mode_bit <= cri_pkg::PRIV_INIT;
            psw_reg.interrupt_mask_field <= cri_pkg::IMASK_INIT;
            psw_reg.max_mode <= cri_pkg::MAX_INIT;
            psw_reg.register_bank_pointer <= cri_pkg::RFP_INIT;
            // flags keep their value through reset
            psw_reg.flags <= psw_reg.flags;
        end else if (wr_en && req.address == cri_pkg::OFS_PSW) begin
            psw_reg <= psw_wr;
        end
    end

    // general register is cleared only by power-on, never by the pin
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gpr_reg <= 32'h00000000;
        end else if (!in_reset && wr_en &&
                     req.address == cri_pkg::OFS_GPR) begin
            gpr_reg <= (req.writedata & wmask) | (gpr_reg & ~wmask);
        end
    end

    ////////////////////////////////////////////////////////////////
    // ports and peripheral control
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pdir_reg <= cri_pkg::PDIR_INIT;
            pfunc_reg <= cri_pkg::PFUNC_INIT;
            pout_reg <= cri_pkg::POUT_INIT;
        end else if (in_reset) begin
            pdir_reg <= cri_pkg::PDIR_INIT;
            pfunc_reg <= cri_pkg::PFUNC_INIT;
            pout_reg <= cri_pkg::POUT_INIT;
        end else if (wr_en && req.byteenable[0]) begin
            if (req.address == cri_pkg::OFS_PDIR) begin
                pdir_reg <= req.writedata[7:0];
            end
            if (req.address == cri_pkg::OFS_PFUNC) begin
                pfunc_reg <= req.writedata[7:0];
            end
            if (req.address == cri_pkg::OFS_POUT) begin
                pout_reg <= req.writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            periph_reg <= cri_pkg::PERIPH_INIT;
        end else if (in_reset) begin
            periph_reg <= cri_pkg::PERIPH_INIT;
        end else if (wr_en && req.address == cri_pkg::OFS_PERIPH) begin
            periph_reg <= (req.writedata[15:0] & wmask[15:0]) |
                          (periph_reg & ~wmask[15:0]);
        end
    end

    assign port_out = pout_reg;
    assign port_oe_n = ~pdir_reg;
    assign port_func = pfunc_reg;
    assign periph_ctrl = periph_reg;

    ////////////////////////////////////////////////////////////////
    // watchdog: expiry sets the pin, expiry beats a clear
    assign wdt_clr = wr_en && req.address == cri_pkg::OFS_WDT &&
                     req.byteenable[0] && req.writedata[cri_pkg::WDT_CLR_BIT];
    assign wdt_fire = wdt_en_reg && wdt_cnt_reg == 32'(WDT_CYC - 1);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdt_en_reg <= cri_pkg::WDT_EN_INIT;
        end else if (in_reset) begin
            wdt_en_reg <= cri_pkg::WDT_EN_INIT;
        end else if (wr_en && req.address == cri_pkg::OFS_WDT &&
                     req.byteenable[0]) begin
            wdt_en_reg <= req.writedata[cri_pkg::WDT_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdt_cnt_reg <= 32'h00000000;
        end else if (in_reset || wdt_clr || wdt_fire || !wdt_en_reg) begin
            wdt_cnt_reg <= 32'h00000000;
        end else begin
            wdt_cnt_reg <= wdt_cnt_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wdt_pin_reg <= 1'b0;
        end else if (in_reset) begin
            wdt_pin_reg <= 1'b0;
        end else if (wdt_fire) begin
            wdt_pin_reg <= 1'b1;
        end else if (wdt_clr) begin
            wdt_pin_reg <= 1'b0;
        end
    end

    assign watchdog_output_pin = wdt_pin_reg;

    ////////////////////////////////////////////////////////////////
    // clock output: clk_sys divided by four, released high in reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_reg <= cri_pkg::CLKDIV_INIT;
            clk_out_reg <= 1'b1;
            clk_out_oe_n <= 1'b1;
        end else if (in_reset) begin
            div_reg <= cri_pkg::CLKDIV_INIT;
            clk_out_reg <= 1'b1;
            clk_out_oe_n <= 1'b1;
        end else begin
            div_reg <= div_reg + 2'h1;
            clk_out_reg <= ~div_reg[1];
            clk_out_oe_n <= 1'b0;
        end
    end

    assign clk_out = clk_out_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cpu_run <= 1'b0;
        end else begin
            cpu_run <= ~in_reset & reset_pin_n;
        end
    end

    assign fetch_addr = pc_reg;

    ////////////////////////////////////////////////////////////////
    // external bus cycle and bus release
    assign bus_start = wr_en && req.address == cri_pkg::OFS_BUS;

    always_comb begin
        bus_next = bus_reg;
        case (bus_reg)
            cri_pkg::BUS_IDLE: begin
                if (!bus_release_request_n) begin
                    bus_next = cri_pkg::BUS_REL;
                end else if (bus_start) begin
                    bus_next = cri_pkg::BUS_ALE;
                end
            end
            cri_pkg::BUS_ALE: bus_next = cri_pkg::BUS_STROBE;
            cri_pkg::BUS_STROBE: begin
                if (!wait_n) begin
                    bus_next = cri_pkg::BUS_WAIT;
                end else if (!bus_release_request_n) begin
                    bus_next = cri_pkg::BUS_REL;
                end else begin
                    bus_next = cri_pkg::BUS_IDLE;
                end
            end
            // release is held off until the wait request drops
            cri_pkg::BUS_WAIT: begin
                if (wait_n) begin
                    bus_next = bus_release_request_n ? cri_pkg::BUS_IDLE
                                                     : cri_pkg::BUS_REL;
                end
            end
            cri_pkg::BUS_REL: begin
                if (bus_release_request_n) begin
                    bus_next = cri_pkg::BUS_IDLE;
                end
            end
            default: bus_next = cri_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus_reg <= cri_pkg::BUS_IDLE;
        end else if (in_reset) begin
            bus_reg <= cri_pkg::BUS_IDLE;
        end else begin
            bus_reg <= bus_next;
        end
    end

    assign ale = bus_reg == cri_pkg::BUS_ALE;
    assign bus_release_grant_n = bus_reg != cri_pkg::BUS_REL;

    ////////////////////////////////////////////////////////////////
    // run length of low pin samples, saturating, so the check needs no long repeat
    logic [31:0] low_run_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_run_reg <= 32'h00000000;
        end else if (reset_pin_n) begin
            low_run_reg <= 32'h00000000;
        end else if (low_run_reg < 32'(RST_CYC)) begin
            low_run_reg <= low_run_reg + 32'h00000001;
        end
    end

    // the pin is sampled low for the last of the required clocks
    sequence s_pin_low_long;
        !reset_pin_n && low_run_reg >= 32'(RST_CYC - 1);
    endsequence

    sequence s_reset_held;
        in_reset ##1 in_reset;
    endsequence

    AST_ACCEPT: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_pin_low_long |=> in_reset)
        else $error("reset not accepted after ten low clocks");
    AST_NO_EARLY: assert property (@(posedge clk_sys) disable iff (!nrst)
        reset_pin_n |=> !in_reset)
        else $error("reset accepted with pin high");
    AST_PC_INIT: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_reset_held |-> pc_reg == 24'h008000)
        else $error("program counter not 8000h in reset");
    AST_XSP_INIT: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset |=> xsp_reg == 32'h00000100)
        else $error("stack pointer not 100h in reset");
    AST_PRIV: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset |=> psw_reg.privilege_mode_bit)
        else $error("privilege bit clear in reset");
    AST_IMASK: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset |=> psw_reg.interrupt_mask_field == 3'h7)
        else $error("interrupt mask not 111 in reset");
    AST_MAX_RFP: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset |=> !psw_reg.max_mode &&
        psw_reg.register_bank_pointer == 3'h0)
        else $error("mode bit or bank pointer wrong in reset");
    AST_KEEP: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset |=> $stable(psw_reg.flags) && $stable(gpr_reg))
        else $error("cpu register changed by reset");
    AST_PERIPH: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset |=> periph_ctrl == 16'h0000)
        else $error("peripheral register not initial in reset");
    AST_PORTS: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_reset_held |-> port_oe_n == 8'hff && port_func == 8'h00)
        else $error("ports not inputs in reset");
    AST_WDT: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset ##1 !in_reset |-> !watchdog_output_pin && wdt_en_reg)
        else $error("watchdog pin or enable wrong after reset");
    AST_CLK: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_reset_held |-> clk_out && clk_out_oe_n)
        else $error("clock output not pulled high in reset");
    AST_ALE: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_reset |=> !ale)
        else $error("ale high during reset");
    AST_BUSREL: assert property (@(posedge clk_sys) disable iff (!nrst)
        bus_reg == cri_pkg::BUS_WAIT && !wait_n |=>
        bus_release_grant_n)
        else $error("bus released during wait");
endmodule // cri_reset_core
`default_nettype wire

// ==== dv/cri_reset_src.sv ====
// external reset supervisor model driving the device reset pin
// assumes go is a one-cycle pulse launched just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module cri_reset_src (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [7:0] low_len,
    output logic reset_pin_n
);
    logic [7:0] cnt_reg;
    // pin idles high through its pull-up
    initial begin
        reset_pin_n = 1'b1;
        cnt_reg = 8'h00;
    end
    // holds the pin low for exactly low_len clocks; short pulses are legal stimulus too
    always @(posedge clk_sys) begin
        if (go && cnt_reg == 8'h00) begin
            reset_pin_n <= 1'b0;
            cnt_reg <= low_len;
        end else if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else if (cnt_reg == 8'h01) begin
            cnt_reg <= 8'h00;
            reset_pin_n <= 1'b1;
        end
    end
endmodule // cri_reset_src
`default_nettype wire

// ==== dv/test_cpu_reset_initial_state.sv ====
// self-checking bench for the reset and initial-state core
// assumes the package and design files are compiled before it
`timescale 1ns/100ps
`default_nettype none
module test_cpu_reset_initial_state;
    logic clk_sys, nrst, go, wait_n, breq_n, pin_n, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, seed, tmp;
    logic [3:0] avs_byteenable;
    logic [7:0] port_in, port_oe_n, port_func, low_len;
    logic wdt, clk_out, ale, grant_n, cpu_run;
    logic [23:0] fetch_addr;
    int err_total, check_count, n;
    logic [5:0] ofs [7] = '{cri_pkg::OFS_PC, cri_pkg::OFS_XSP, cri_pkg::OFS_PSW,
        cri_pkg::OFS_GPR, cri_pkg::OFS_PDIR, cri_pkg::OFS_PFUNC, cri_pkg::OFS_PERIPH};
    logic [31:0] msk [7] = '{32'h00ffffff, 32'hffffffff, 32'h0000ffff, 32'hffffffff,
        32'h000000ff, 32'h000000ff, 32'h0000ffff};
    logic [31:0] mdl [7];
    cri_reset_core #(.RST_CYC(10), .WDT_CYC(16)) cri_reset_core_inst (
        .clk_sys(clk_sys), .nrst(nrst), .reset_pin_n(pin_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_in(port_in), .port_out(),
        .port_oe_n(port_oe_n), .port_func(port_func), .periph_ctrl(),
        .watchdog_output_pin(wdt), .clk_out(clk_out), .clk_out_oe_n(), .ale(ale),
        .wait_n(wait_n), .bus_release_request_n(breq_n), .bus_release_grant_n(grant_n),
        .cpu_run(cpu_run), .fetch_addr(fetch_addr));
    cri_reset_src cri_reset_src_inst (.clk_sys(clk_sys), .go(go), .low_len(low_len),
        .reset_pin_n(pin_n));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // master side: rd is taken at the completion edge, request released after it
    task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 50) err_total++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic cmp_all();
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, ofs[i], 32'h0);
            chk(rd, mdl[i]);
        end
        chk({24'h0, port_oe_n, port_func}, {24'h0, ~mdl[4][7:0], mdl[5][7:0]});
    endtask
    task automatic pulse(input logic [7:0] len);
        low_len <= len;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, go, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {wait_n, breq_n, avs_byteenable, port_in, low_len} = {2'h3, 4'hf, 8'h00, 8'h00};
        {err_total, check_count, seed} = {32'h0, 32'h0, 32'h25};
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({8'h0, fetch_addr}, 32'h00008000);
        chk({23'h0, port_oe_n, wdt}, {23'h0, 8'hff, 1'b0});
        @(posedge clk_sys);
        bus(1'b0, cri_pkg::OFS_PSW, 32'h0);
        chk(rd & 32'hff00, 32'hf000);
        bus(1'b0, cri_pkg::OFS_XSP, 32'h0);
        chk(rd, 32'h00000100);
        for (int i = 0; i < 7; i++) begin
            mdl[i] = xs() & msk[i];
            bus(1'b1, ofs[i], mdl[i]);
        end
        tmp = xs();
        port_in <= tmp[7:0];
        cmp_all();
        bus(1'b0, cri_pkg::OFS_PIN, 32'h0);
        chk(rd, {24'h0, tmp[7:0]});
        bus(1'b0, 6'h3c, 32'h0);
        chk(rd, 32'h0);
        // nine low clocks fall short of acceptance
        pulse(8'h09);
        repeat (12) @(posedge clk_sys);
        cmp_all();
        pulse(8'h0c);
        repeat (11) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({28'h0, clk_out, ale, wdt, cpu_run}, 32'h8);
        chk({8'h0, fetch_addr}, 32'h00008000);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, cpu_run}, 32'h1);
        mdl[0] = 32'h00008000;
        mdl[1] = 32'h00000100;
        mdl[2] = 32'hf000 | (mdl[2] & 32'hff);
        {mdl[4], mdl[5], mdl[6]} = '0;
        cmp_all();
        chk({31'h0, wdt}, 32'h1);
        // clear the expired watchdog, keep it enabled, then look at status
        bus(1'b1, cri_pkg::OFS_WDT, 32'h3);
        bus(1'b0, cri_pkg::OFS_WDT, 32'h0);
        chk(rd, 32'h1);
        bus(1'b0, cri_pkg::OFS_STAT, 32'h0);
        chk(rd, 32'h6);
        // bus cycle stretched by wait, then a release request arrives
        wait_n <= 1'b0;
        bus(1'b1, cri_pkg::OFS_BUS, 32'h0);
        breq_n <= 1'b0;
        repeat (6) begin
            @(negedge clk_sys);
            chk({31'h0, grant_n}, 32'h1);
        end
        @(posedge clk_sys);
        wait_n <= 1'b1;
        n = 0;
        while (grant_n !== 1'b0 && n < 10) begin
            n++;
            @(posedge clk_sys);
        end
        chk({31'h0, grant_n}, 32'h0);
        breq_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, grant_n}, 32'h1);
        conclude();
    end
endmodule // test_cpu_reset_initial_state
`default_nettype wire
